/* File: pkg/tmr2_pkg.sv */
// shared constants for the third timer/counter block
package tmr2_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_RELOAD_LOW = 8'h0C;
  localparam logic [7:0] OFS_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h14;
  // timer2_control field positions
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXT_EVENT_FLAG = 6;
  localparam int BIT_UART1_RX_SEL = 5;
  localparam int BIT_UART1_TX_SEL = 4;
  localparam int BIT_EXT_TRIG_EN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNT_SEL = 1;
  localparam int BIT_CAPTURE_SEL = 0;
  // power_control field positions
  localparam int BIT_UART2_RX_SEL = 1;
  localparam int BIT_UART2_TX_SEL = 0;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [1:0] RST_POWER_CONTROL = 2'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  // one machine cycle is twelve system clocks
  localparam int MACHINE_CYCLE_CLKS = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(MACHINE_CYCLE_CLKS - 1);
endpackage

/* File: pkg/tmr2_cnt_if.sv */
// carrier between the register side and the 16-bit counter core
`timescale 1ns/1ps
`default_nettype none
interface tmr2_cnt_if;
  logic tick;
  logic auto_reload;
  logic force_load;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [15:0] reload_val;
  logic [15:0] count;
  logic ovf;
  modport core (
    input tick, auto_reload, force_load, wr_low, wr_high, wdata, reload_val,
    output count, ovf
  );
  modport ctrl (
    output tick, auto_reload, force_load, wr_low, wr_high, wdata, reload_val,
    input count, ovf
  );
endinterface
`default_nettype wire

/* File: hw/tmr2_fall_det.sv */
// pin synchroniser with falling edge detection
`timescale 1ns/1ps
`default_nettype none
module tmr2_fall_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // idle level of both pins is high, so no edge is seen at release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg; // RQ19
      prev_reg <= sync_reg;
    end
  end

  // high sample followed by low sample
  assign fall = prev_reg & ~sync_reg; // RQ19
endmodule
`default_nettype wire

/* File: hw/tmr2_counter.sv */
// 16-bit up counter with rollover and reload
`timescale 1ns/1ps
`default_nettype none
module tmr2_counter
  import tmr2_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tmr2_cnt_if.core cif
);
  logic [15:0] count_reg;
  logic rollover;

  assign rollover = cif.tick && (count_reg == COUNT_ALL_ONES); // RQ20
  assign cif.count = count_reg;
  assign cif.ovf = rollover;

  // software byte writes win over counting in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= RST_COUNT;
    end else if (cif.wr_low || cif.wr_high) begin
      if (cif.wr_low) begin
        count_reg[7:0] <= cif.wdata;
      end
      if (cif.wr_high) begin
        count_reg[15:8] <= cif.wdata;
      end
    end else if (cif.force_load) begin
      count_reg <= cif.reload_val; // RQ6
    end else if (rollover) begin
      if (cif.auto_reload) begin
        count_reg <= cif.reload_val; // RQ5
      end else begin
        count_reg <= RST_COUNT; // RQ2
      end
    end else if (cif.tick) begin
      count_reg <= count_reg + 16'h0001; // RQ18
    end
  end
endmodule
`default_nettype wire

/* File: hw/tmr2_top.sv */
// timer 2: capture, auto-reload and baud clock source behind an APB slave
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: count_select picks machine cycles or pin edges
// RQ2: capture mode rollover sets overflow_flag
// RQ3: trigger edge captures count into reload registers
// RQ4: capturing trigger edge sets external_event_flag
// RQ5: auto-reload rollover sets flag and reloads
// RQ6: trigger edge forces reload, sets event flag
// RQ7: any uart clock select means baud mode
// RQ8: baud mode overflow never sets overflow_flag
// RQ9: baud mode ignores capture select, always reloads
// RQ10: baud mode trigger edge only sets event flag
// RQ11: trigger disabled means trigger edges ignored
// RQ12: counter advances only while timer2_run set
// RQ13: uart1 receive clock from timer 2 or 1
// RQ14: uart1 transmit clock from timer 2 or 1
// RQ15: power_control bits steer uart2 clocks likewise
// RQ16: software alone clears both flags
// RQ17: set event flag raises timer 2 request
// RQ18: capture mode counts upward only
// RQ19: pins synchronised, falling edge detected
// RQ20: overflow is all ones to zero or reload
module tmr2_top
  import tmr2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_input,
  input wire logic count_input,
  input wire logic timer1_ovf,
  output logic timer2_irq,
  output logic timer2_ovf,
  output logic uart1_rx_clk,
  output logic uart1_tx_clk,
  output logic uart2_rx_clk,
  output logic uart2_tx_clk
);
  tmr2_cnt_if cif ();

  logic [7:0] control_reg;
  logic [1:0] power_control_reg;
  logic [15:0] reload_reg;
  logic [3:0] prescale_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic ovf_reg;
  logic u1rx_reg;
  logic u1tx_reg;
  logic u2rx_reg;
  logic u2tx_reg;

  logic trig_fall;
  logic cnt_fall;
  logic mc_tick;
  logic baud_mode;
  logic trig_en;
  logic trig_event;
  logic do_capture;
  logic do_force_reload;
  logic set_overflow;
  logic set_event;
  logic setup_phase;
  logic wr_access;
  logic [7:0] control_next;

  // true when the address hits one of the six words
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_CONTROL) || (a == OFS_COUNT_LOW) ||
                  (a == OFS_COUNT_HIGH) || (a == OFS_RELOAD_LOW) ||
                  (a == OFS_RELOAD_HIGH) || (a == OFS_POWER_CONTROL);
  endfunction

  // write strobe for one word of the map
  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  tmr2_fall_det u_trig_det (
    .clk(pclk),
    .rst_n(presetn),
    .pin(trigger_input),
    .fall(trig_fall)
  );

  tmr2_fall_det u_cnt_det (
    .clk(pclk),
    .rst_n(presetn),
    .pin(count_input),
    .fall(cnt_fall)
  );

  tmr2_counter u_counter (
    .clk(pclk),
    .rst_n(presetn),
    .cif(cif)
  );

  // bus phases: one wait-free access cycle after each setup
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // mode decode
  assign baud_mode = control_reg[BIT_UART1_RX_SEL] | control_reg[BIT_UART1_TX_SEL] |
                     power_control_reg[BIT_UART2_RX_SEL] |
                     power_control_reg[BIT_UART2_TX_SEL]; // RQ7
  assign trig_en = control_reg[BIT_EXT_TRIG_EN];
  assign trig_event = trig_en && trig_fall; // RQ11
  assign do_capture = trig_event && !baud_mode &&
                      control_reg[BIT_CAPTURE_SEL]; // RQ3
  assign do_force_reload = trig_event && !baud_mode &&
                           !control_reg[BIT_CAPTURE_SEL]; // RQ6

  // machine cycle prescaler, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= 4'h0;
    end else if (prescale_reg == PRESCALE_LAST) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end
  assign mc_tick = (prescale_reg == PRESCALE_LAST);

  // counter drive
  assign cif.tick = control_reg[BIT_RUN] &&
                    (control_reg[BIT_COUNT_SEL] ? cnt_fall : mc_tick); // RQ1 RQ12
  assign cif.auto_reload = baud_mode || !control_reg[BIT_CAPTURE_SEL]; // RQ9
  assign cif.force_load = do_force_reload;
  assign cif.wr_low = wr_hit(wr_access, paddr, OFS_COUNT_LOW);
  assign cif.wr_high = wr_hit(wr_access, paddr, OFS_COUNT_HIGH);
  assign cif.wdata = pwdata[7:0];
  assign cif.reload_val = reload_reg;

  // flag sources
  assign set_overflow = cif.ovf && !baud_mode; // RQ2 RQ5 RQ8
  assign set_event = trig_event; // RQ4 RQ6 RQ10

  // control byte: hardware set wins over a software clear
  always_comb begin
    control_next = control_reg;
    if (wr_hit(wr_access, paddr, OFS_CONTROL)) begin
      control_next = pwdata[7:0];
    end
    if (set_overflow) begin
      control_next[BIT_OVERFLOW_FLAG] = 1'b1; // RQ16
    end
    if (set_event) begin
      control_next[BIT_EXT_EVENT_FLAG] = 1'b1; // RQ16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= RST_CONTROL;
    end else begin
      control_reg <= control_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= RST_POWER_CONTROL;
    end else if (wr_hit(wr_access, paddr, OFS_POWER_CONTROL)) begin
      power_control_reg <= pwdata[1:0]; // RQ15
    end
  end

  // reload/capture pair; a capture beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= RST_RELOAD;
    end else if (do_capture) begin
      reload_reg <= cif.count; // RQ3
    end else begin
      if (wr_hit(wr_access, paddr, OFS_RELOAD_LOW)) begin
        reload_reg[7:0] <= pwdata[7:0];
      end
      if (wr_hit(wr_access, paddr, OFS_RELOAD_HIGH)) begin
        reload_reg[15:8] <= pwdata[7:0];
      end
    end
  end

  // request stays high until software clears both flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= control_next[BIT_OVERFLOW_FLAG] |
                 control_next[BIT_EXT_EVENT_FLAG]; // RQ17
    end
  end

  // serial clock steering, one registered stage of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
      u1rx_reg <= 1'b0;
      u1tx_reg <= 1'b0;
      u2rx_reg <= 1'b0;
      u2tx_reg <= 1'b0;
    end else begin
      ovf_reg <= cif.ovf;
      u1rx_reg <= control_reg[BIT_UART1_RX_SEL] ? cif.ovf : timer1_ovf; // RQ13
      u1tx_reg <= control_reg[BIT_UART1_TX_SEL] ? cif.ovf : timer1_ovf; // RQ14
      u2rx_reg <= power_control_reg[BIT_UART2_RX_SEL] ? cif.ovf : timer1_ovf; // RQ15
      u2tx_reg <= power_control_reg[BIT_UART2_TX_SEL] ? cif.ovf : timer1_ovf; // RQ15
    end
  end

  // answer in the cycle after setup; read data sampled at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !addr_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      unique case (paddr)
        OFS_CONTROL: prdata_reg <= {24'h000000, control_reg};
        OFS_COUNT_LOW: prdata_reg <= {24'h000000, cif.count[7:0]};
        OFS_COUNT_HIGH: prdata_reg <= {24'h000000, cif.count[15:8]};
        OFS_RELOAD_LOW: prdata_reg <= {24'h000000, reload_reg[7:0]};
        OFS_RELOAD_HIGH: prdata_reg <= {24'h000000, reload_reg[15:8]};
        OFS_POWER_CONTROL: prdata_reg <= {30'h0, power_control_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer2_irq = irq_reg;
  assign timer2_ovf = ovf_reg;
  assign uart1_rx_clk = u1rx_reg;
  assign uart1_tx_clk = u1tx_reg;
  assign uart2_rx_clk = u2rx_reg;
  assign uart2_tx_clk = u2tx_reg;
endmodule
`default_nettype wire

/* File: sim/tmr2_properties.sv */
// port-level checker for the timer 2 block
`timescale 1ns/1ps
`default_nettype none
module tmr2_properties
  import tmr2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger_input,
  input wire logic count_input,
  input wire logic timer1_ovf,
  input wire logic timer2_irq,
  input wire logic timer2_ovf,
  input wire logic uart1_rx_clk,
  input wire logic uart1_tx_clk,
  input wire logic uart2_rx_clk,
  input wire logic uart2_tx_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic setup_seen;
  logic ctl_write;
  assign mapped = (paddr <= OFS_POWER_CONTROL) && (paddr[1:0] == 2'h0);
  assign setup_seen = psel && !penable;
  assign ctl_write = psel && penable && pready && pwrite && (paddr == OFS_CONTROL);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(setup_seen)) else $error("stray ready");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("data on error");
  ovf_pulse_a: assert property (timer2_ovf |=> !timer2_ovf) else $error("overflow pulse too long");
  // request follows the flags directly, so it drops right after the clearing write
  irq_hold_a: assert property ($fell(timer2_irq) |-> $past(ctl_write))
    else $error("request dropped without clear");
  u1rx_source_a: assert property (uart1_rx_clk |-> timer2_ovf || $past(timer1_ovf))
    else $error("uart1 rx clock without source");
  u1tx_source_a: assert property (uart1_tx_clk |-> timer2_ovf || $past(timer1_ovf))
    else $error("uart1 tx clock without source");
  u2rx_source_a: assert property (uart2_rx_clk |-> timer2_ovf || $past(timer1_ovf))
    else $error("uart2 rx clock without source");
  u2tx_source_a: assert property (uart2_tx_clk |-> timer2_ovf || $past(timer1_ovf))
    else $error("uart2 tx clock without source");
  cover property (timer2_ovf);
  cover property ($fell(trigger_input));
  cover property (pready && pslverr);
  cover property ($fell(timer2_irq));
endmodule
bind tmr2_top tmr2_properties tmr2_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input, .count_input, .timer1_ovf,
  .timer2_irq, .timer2_ovf, .uart1_rx_clk, .uart1_tx_clk, .uart2_rx_clk, .uart2_tx_clk);
`default_nettype wire

/* File: sim/tmr2_pin_model.sv */
// trigger, count and timer 1 overflow sources outside the block
`timescale 1ns/1ps
`default_nettype none
module tmr2_pin_model (
  input wire logic pclk,
  output logic trigger_input,
  output logic count_input,
  output logic timer1_ovf
);
  int div;
  initial begin
    trigger_input = 1'b1;
    count_input = 1'b1;
    timer1_ovf = 1'b0;
    div = 0;
  end
  // free timer 1 overflow, one-cycle pulses
  always @(posedge pclk) begin
    div <= (div == 39) ? 0 : div + 1;
    timer1_ovf <= (div == 39);
  end
  // pins pulled high; low and high phases exceed the two-sample minimum
  task fall(input bit trig);
    @(posedge pclk);
    if (trig) trigger_input <= 1'b0;
    else count_input <= 1'b0;
    repeat (3) @(posedge pclk);
    trigger_input <= 1'b1;
    count_input <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the timer 2 block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmr2_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, trigger_input, count_input, timer1_ovf, timer2_irq, timer2_ovf;
  logic uart1_rx_clk, uart1_tx_clk, uart2_rx_clk, uart2_tx_clk, err;
  logic t1_d = 1'b0;
  int miscompares = 0, num_checks = 0, u2_seen = 0, clk_bad = 0;
  always #50 pclk = ~pclk;
  // unselected serial clocks repeat timer 1 overflow one cycle late
  always @(posedge pclk) begin
    t1_d <= presetn ? timer1_ovf : 1'b0;
    if (uart2_tx_clk === 1'b1) u2_seen <= u2_seen + 1;
    if (presetn && (uart1_rx_clk !== t1_d || uart1_tx_clk !== t1_d ||
        uart2_rx_clk !== t1_d)) clk_bad <= clk_bad + 1;
  end
  tmr2_pin_model tmr2_pin_model_inst (.pclk(pclk), .trigger_input(trigger_input),
    .count_input(count_input), .timer1_ovf(timer1_ovf));
  tmr2_top tmr2_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input(trigger_input), .count_input(count_input),
    .timer1_ovf(timer1_ovf), .timer2_irq(timer2_irq), .timer2_ovf(timer2_ovf),
    .uart1_rx_clk(uart1_rx_clk), .uart1_tx_clk(uart1_tx_clk), .uart2_rx_clk(uart2_rx_clk),
    .uart2_tx_clk(uart2_tx_clk));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, {24'h0, e}, q);
  endtask
  task t_regs;
    rd("control reset", OFS_CONTROL, 8'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped data", 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task t_capture;
    wr(OFS_COUNT_LOW, 8'h34);
    wr(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_CONTROL, 8'h0F);
    tmr2_pin_model_inst.fall(1'b1);
    rd("capture low", OFS_RELOAD_LOW, 8'h34);
    rd("capture high", OFS_RELOAD_HIGH, 8'h12);
    rd("event flag", OFS_CONTROL, 8'h4F);
    chk("irq", 32'h1, {31'h0, timer2_irq});
    tmr2_pin_model_inst.fall(1'b0);
    tmr2_pin_model_inst.fall(1'b0);
    rd("pin count", OFS_COUNT_LOW, 8'h36);
    wr(OFS_CONTROL, 8'h0B);
    tmr2_pin_model_inst.fall(1'b0);
    rd("stopped count", OFS_COUNT_LOW, 8'h36);
    wr(OFS_CONTROL, 8'h06);
    tmr2_pin_model_inst.fall(1'b1);
    rd("trigger off", OFS_CONTROL, 8'h06);
    rd("no forced reload", OFS_COUNT_LOW, 8'h36);
    chk("irq cleared", 32'h0, {31'h0, timer2_irq});
  endtask
  task t_reload;
    wr(OFS_RELOAD_LOW, 8'hCD);
    wr(OFS_RELOAD_HIGH, 8'hAB);
    wr(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_COUNT_HIGH, 8'hFF);
    tmr2_pin_model_inst.fall(1'b0);
    rd("reload low", OFS_COUNT_LOW, 8'hCD);
    rd("reload high", OFS_COUNT_HIGH, 8'hAB);
    rd("overflow flag", OFS_CONTROL, 8'h86);
    wr(OFS_CONTROL, 8'h0E);
    wr(OFS_COUNT_LOW, 8'h00);
    tmr2_pin_model_inst.fall(1'b1);
    rd("forced reload", OFS_COUNT_LOW, 8'hCD);
    rd("forced flag", OFS_CONTROL, 8'h4E);
  endtask
  task t_baud;
    int u2_before;
    wr(OFS_POWER_CONTROL, 8'h01);
    wr(OFS_CONTROL, 8'h0F);
    wr(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_COUNT_HIGH, 8'hFF);
    u2_before = u2_seen;
    tmr2_pin_model_inst.fall(1'b0);
    rd("baud reload", OFS_COUNT_LOW, 8'hCD);
    rd("no overflow flag", OFS_CONTROL, 8'h0F);
    chk("uart2 clock", u2_before + 1, u2_seen);
    wr(OFS_RELOAD_LOW, 8'h55);
    tmr2_pin_model_inst.fall(1'b1);
    rd("baud event", OFS_CONTROL, 8'h4F);
    rd("no capture", OFS_RELOAD_LOW, 8'h55);
  endtask
  task t_timer;
    logic [7:0] first;
    wr(OFS_POWER_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h07);
    wr(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_COUNT_HIGH, 8'hFF);
    tmr2_pin_model_inst.fall(1'b0);
    rd("capture rollover", OFS_COUNT_HIGH, 8'h00);
    rd("capture overflow", OFS_CONTROL, 8'h87);
    wr(OFS_CONTROL, 8'h05);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    first = q[7:0];
    // both reads sample 120 clocks apart, so exactly ten machine cycles
    repeat (117) @(posedge pclk);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    chk("machine ticks", 32'(120 / MACHINE_CYCLE_CLKS), {24'h0, q[7:0] - first});
    chk("serial clock source", 32'h0, clk_bad);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_capture();
    t_reload();
    t_baud();
    t_timer();
    conclude();
  end
  // whole run is a few hundred cycles; far margin before giving up
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
